// [sbs_pkg.sv]
// Function
// - A write to the full transmit buffer deletes one frame and sets transmit overflow bit 7.
// - A read from the empty transmit buffer repeats one frame and sets transmit underflow bit 6.
// - Transmit slip bit 5 is set by either a transmit frame deletion or a frame repetition.
// - An event flag reads 1 if its event came since the last status read or write of one to its bit, either of which clears it.
// - Read-only bit 4 shows 1 while loop-carrier framing holds frame sync and 0 otherwise.
// - Read-only bit 3 shows the current receive multiframe lock, with 0 meaning loss of lock.
// - A write to the full receive buffer deletes one frame and sets receive overflow bit 2.
// - A read from the empty receive buffer repeats one frame and sets receive underflow bit 1.
// - Receive slip bit 0 is set by either a receive frame deletion or a frame repetition.
package sbs_pkg;
    localparam int SBS_ADDR_W = 4;
    localparam int SBS_DATA_W = 8;

    // Register offsets
    localparam logic [SBS_ADDR_W-1:0] SBS_STATUS_OFS = 4'h0;
    localparam logic [SBS_ADDR_W-1:0] SBS_ENABLE_OFS = 4'h1;
    localparam logic [SBS_ADDR_W-1:0] SBS_TX_CNT_OFS = 4'h2;
    localparam logic [SBS_ADDR_W-1:0] SBS_RX_CNT_OFS = 4'h3;

    // Status and enable bit positions
    localparam int SBS_TX_OVF_BIT = 7;
    localparam int SBS_TX_UNF_BIT = 6;
    localparam int SBS_TX_SLIP_BIT = 5;
    localparam int SBS_LC_SYNC_BIT = 4;
    localparam int SBS_MF_LOCK_BIT = 3;
    localparam int SBS_RX_OVF_BIT = 2;
    localparam int SBS_RX_UNF_BIT = 1;
    localparam int SBS_RX_SLIP_BIT = 0;

    // Bits that are sticky event flags
    localparam logic [SBS_DATA_W-1:0] SBS_EVENT_MASK = 8'hE7;

    // Values after reset and the counter saturation value
    localparam logic [SBS_DATA_W-1:0] SBS_STATUS_RST = 8'h00;
    localparam logic [SBS_DATA_W-1:0] SBS_ENABLE_RST = 8'h00;
    localparam logic [SBS_DATA_W-1:0] SBS_CNT_RST = 8'h00;
    localparam logic [SBS_DATA_W-1:0] SBS_CNT_MAX = 8'hFF;
endpackage

// [sbs_slip_status.sv]
`timescale 1ns/1ps
`default_nettype none
module sbs_slip_status (
    // Clock, reset, freeze
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    // Register port
    input wire logic [sbs_pkg::SBS_ADDR_W-1:0] reg_addr,
    input wire logic [sbs_pkg::SBS_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [sbs_pkg::SBS_DATA_W-1:0] reg_rdata,
    // Transmit slip buffer
    input wire logic tx_buf_full,
    input wire logic tx_buf_wr,
    input wire logic tx_buf_empty,
    input wire logic tx_buf_rd,
    output logic tx_frame_drop,
    output logic tx_frame_repeat,
    // Receive slip buffer
    input wire logic rx_buf_full,
    input wire logic rx_buf_wr,
    input wire logic rx_buf_empty,
    input wire logic rx_buf_rd,
    output logic rx_frame_drop,
    output logic rx_frame_repeat,
    // Framer state
    input wire logic loop_carrier_frame_sync,
    input wire logic multiframe_lock,
    // Interrupt
    output logic irq
);
    import sbs_pkg::*;

    logic tx_ovf;
    logic tx_unf;
    logic rx_ovf;
    logic rx_unf;
    logic st_rd;
    logic st_wr;
    logic [SBS_DATA_W-1:0] ev_set;
    logic [SBS_DATA_W-1:0] ev_clr;
    logic [SBS_DATA_W-1:0] flags;
    logic [SBS_DATA_W-1:0] status_view;

    logic [SBS_DATA_W-1:0] enable_r;
    logic [SBS_DATA_W-1:0] enable_nxt;
    logic [SBS_DATA_W-1:0] tx_cnt_r;
    logic [SBS_DATA_W-1:0] tx_cnt_nxt;
    logic [SBS_DATA_W-1:0] rx_cnt_r;
    logic [SBS_DATA_W-1:0] rx_cnt_nxt;
    logic [SBS_DATA_W-1:0] rdata_r;
    logic [SBS_DATA_W-1:0] rdata_nxt;
    logic irq_r;
    logic irq_nxt;
    logic tx_drop_r;
    logic tx_drop_nxt;
    logic tx_rep_r;
    logic tx_rep_nxt;
    logic rx_drop_r;
    logic rx_drop_nxt;
    logic rx_rep_r;
    logic rx_rep_nxt;

    // Slip detection: the buffer itself acts on the drop and repeat pulses
    assign tx_ovf = tx_buf_full & tx_buf_wr;
    assign tx_unf = tx_buf_empty & tx_buf_rd;
    assign rx_ovf = rx_buf_full & rx_buf_wr;
    assign rx_unf = rx_buf_empty & rx_buf_rd;

    assign st_rd = reg_rd & (reg_addr == SBS_STATUS_OFS);
    assign st_wr = reg_wr & (reg_addr == SBS_STATUS_OFS);

    always_comb begin
        ev_set = '0;
        ev_set[SBS_TX_OVF_BIT] = tx_ovf;
        ev_set[SBS_TX_UNF_BIT] = tx_unf;
        ev_set[SBS_TX_SLIP_BIT] = tx_ovf | tx_unf;
        ev_set[SBS_RX_OVF_BIT] = rx_ovf;
        ev_set[SBS_RX_UNF_BIT] = rx_unf;
        ev_set[SBS_RX_SLIP_BIT] = rx_ovf | rx_unf;
    end

    // A status read clears every flag; a write of one clears single bits
    always_comb begin
        ev_clr = '0;
        if (st_rd) begin
            ev_clr = SBS_EVENT_MASK;
        end else if (st_wr) begin
            ev_clr = reg_wdata & SBS_EVENT_MASK;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < SBS_DATA_W; gi = gi + 1) begin : g_flag
            if (SBS_EVENT_MASK[gi]) begin : g_ev
                sbs_sticky_flag u_flag (
                    .clock(clock),
                    .rst_n(rst_n),
                    .ce(ce),
                    .set(ev_set[gi]),
                    .clr(ev_clr[gi]),
                    .flag(flags[gi])
                );
            end else begin : g_ro
                assign flags[gi] = 1'b0;
            end
        end
    endgenerate

    // Lock bits are live levels; they are not latched
    always_comb begin
        status_view = flags;
        status_view[SBS_LC_SYNC_BIT] = loop_carrier_frame_sync;
        status_view[SBS_MF_LOCK_BIT] = multiframe_lock;
    end

    // Register file, read data and interrupt
    always_comb begin
        enable_nxt = enable_r;
        if (reg_wr && (reg_addr == SBS_ENABLE_OFS)) begin
            enable_nxt = reg_wdata & SBS_EVENT_MASK;
        end
        rdata_nxt = '0;
        if (reg_rd) begin
            case (reg_addr)
                SBS_STATUS_OFS: rdata_nxt = status_view;
                SBS_ENABLE_OFS: rdata_nxt = enable_r;
                SBS_TX_CNT_OFS: rdata_nxt = tx_cnt_r;
                SBS_RX_CNT_OFS: rdata_nxt = rx_cnt_r;
                default: rdata_nxt = '0;
            endcase
        end
        // Flags record regardless of enables; only the output is gated
        irq_nxt = |(flags & enable_r);
    end

    // Saturating slip counters; any write to a counter zeroes it
    always_comb begin
        tx_cnt_nxt = tx_cnt_r;
        if (reg_wr && (reg_addr == SBS_TX_CNT_OFS)) begin
            tx_cnt_nxt = SBS_CNT_RST;
        end else if ((tx_ovf || tx_unf) && (tx_cnt_r != SBS_CNT_MAX)) begin
            tx_cnt_nxt = tx_cnt_r + 8'h01;
        end
        rx_cnt_nxt = rx_cnt_r;
        if (reg_wr && (reg_addr == SBS_RX_CNT_OFS)) begin
            rx_cnt_nxt = SBS_CNT_RST;
        end else if ((rx_ovf || rx_unf) && (rx_cnt_r != SBS_CNT_MAX)) begin
            rx_cnt_nxt = rx_cnt_r + 8'h01;
        end
    end

    // One-cycle commands to the buffers: drop or repeat one whole frame
    always_comb begin
        tx_drop_nxt = tx_ovf;
        tx_rep_nxt = tx_unf;
        rx_drop_nxt = rx_ovf;
        rx_rep_nxt = rx_unf;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            enable_r <= SBS_ENABLE_RST;
            tx_cnt_r <= SBS_CNT_RST;
            rx_cnt_r <= SBS_CNT_RST;
            rdata_r <= SBS_STATUS_RST;
            irq_r <= 1'b0;
            tx_drop_r <= 1'b0;
            tx_rep_r <= 1'b0;
            rx_drop_r <= 1'b0;
            rx_rep_r <= 1'b0;
        end else if (ce) begin
            enable_r <= enable_nxt;
            tx_cnt_r <= tx_cnt_nxt;
            rx_cnt_r <= rx_cnt_nxt;
            rdata_r <= rdata_nxt;
            irq_r <= irq_nxt;
            tx_drop_r <= tx_drop_nxt;
            tx_rep_r <= tx_rep_nxt;
            rx_drop_r <= rx_drop_nxt;
            rx_rep_r <= rx_rep_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign irq = irq_r;
    assign tx_frame_drop = tx_drop_r;
    assign tx_frame_repeat = tx_rep_r;
    assign rx_frame_drop = rx_drop_r;
    assign rx_frame_repeat = rx_rep_r;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    tx_full_flag_a:
    assert property (ce && tx_buf_full && tx_buf_wr |=> flags[SBS_TX_OVF_BIT] && tx_frame_drop)
    else $error("transmit overflow not flagged or not dropped");

    tx_empty_flag_a:
    assert property (ce && tx_buf_empty && tx_buf_rd |=> flags[SBS_TX_UNF_BIT] && tx_frame_repeat)
    else $error("transmit underflow not flagged or not repeated");

    tx_slip_flag_a:
    assert property (ce && (tx_ovf || tx_unf) |=> flags[SBS_TX_SLIP_BIT])
    else $error("transmit slip not flagged");

    tx_slip_cause_a:
    assert property (ce && !$past(flags[SBS_TX_SLIP_BIT]) ##0 $rose(flags[SBS_TX_SLIP_BIT])
        |-> $past(tx_ovf) || $past(tx_unf))
    else $error("transmit slip flag set without a slip");

    read_clears_a:
    assert property (ce && st_rd && (ev_set == '0) |=> (flags & SBS_EVENT_MASK) == '0)
    else $error("status read did not clear the event flags");

    read_returns_a:
    assert property (ce && st_rd |=> reg_rdata == $past(status_view))
    else $error("status read returned wrong value");

    flag_holds_a:
    assert property (ce && flags[SBS_RX_OVF_BIT] && !reg_rd && !reg_wr
        |=> flags[SBS_RX_OVF_BIT])
    else $error("event flag dropped without a read");

    lc_sync_bit_a:
    assert property (ce && st_rd |=> reg_rdata[SBS_LC_SYNC_BIT] == $past(loop_carrier_frame_sync))
    else $error("loop carrier sync bit wrong");

    mf_lock_bit_a:
    assert property (ce && st_rd |=> reg_rdata[SBS_MF_LOCK_BIT] == $past(multiframe_lock))
    else $error("multiframe lock bit wrong");

    rx_full_flag_a:
    assert property (ce && rx_buf_full && rx_buf_wr |=> flags[SBS_RX_OVF_BIT] && rx_frame_drop)
    else $error("receive overflow not flagged or not dropped");

    rx_empty_flag_a:
    assert property (ce && rx_buf_empty && rx_buf_rd |=> flags[SBS_RX_UNF_BIT] && rx_frame_repeat)
    else $error("receive underflow not flagged or not repeated");

    rx_slip_flag_a:
    assert property (ce && (rx_ovf || rx_unf) |=> flags[SBS_RX_SLIP_BIT])
    else $error("receive slip not flagged");

    set_beats_read_a:
    assert property (ce && st_rd && tx_unf |=> flags[SBS_TX_UNF_BIT] && flags[SBS_TX_SLIP_BIT])
    else $error("event lost in the clearing cycle");

    irq_gating_a:
    assert property (ce |=> irq == $past(|(flags & enable_r)))
    else $error("interrupt does not follow masked flags");

    irq_masked_a:
    assert property (ce && (enable_r == '0) && $past(enable_r == '0) |=> !irq)
    else $error("interrupt raised with all enables off");

    tx_ovf_cause_a:
    assert property ($rose(flags[SBS_TX_OVF_BIT]) |-> $past(tx_ovf))
    else $error("transmit overflow flag set without an overflow");

    tx_unf_cause_a:
    assert property ($rose(flags[SBS_TX_UNF_BIT]) |-> $past(tx_unf))
    else $error("transmit underflow flag set without an underflow");

    rx_slip_cause_a:
    assert property ($rose(flags[SBS_RX_SLIP_BIT]) |-> $past(rx_ovf || rx_unf))
    else $error("receive slip flag set without a slip");

    tx_drop_quiet_a:
    assert property (ce && !tx_ovf |=> !tx_frame_drop)
    else $error("transmit frame dropped without an overflow");

    tx_rep_quiet_a:
    assert property (ce && !tx_unf |=> !tx_frame_repeat)
    else $error("transmit frame repeated without an underflow");

    rx_drop_quiet_a:
    assert property (ce && !rx_ovf |=> !rx_frame_drop)
    else $error("receive frame dropped without an overflow");

    rx_rep_quiet_a:
    assert property (ce && !rx_unf |=> !rx_frame_repeat)
    else $error("receive frame repeated without an underflow");

    flags_sticky_a:
    assert property (ce && !st_rd && !st_wr |=> (flags & $past(flags)) == $past(flags))
    else $error("event flag lost without a clear");

    write_clears_a:
    assert property (ce && st_wr && (ev_set == '0)
        |=> (flags & $past(reg_wdata & SBS_EVENT_MASK)) == '0)
    else $error("write of one did not clear the flag");

    rdata_idle_a:
    assert property (ce && !reg_rd |=> reg_rdata == '0)
    else $error("read data not zero outside a read");

    enable_write_a:
    assert property (ce && reg_wr && (reg_addr == SBS_ENABLE_OFS)
        |=> enable_r == ($past(reg_wdata) & SBS_EVENT_MASK))
    else $error("enable register write lost");

    enable_hold_a:
    assert property (ce && !(reg_wr && (reg_addr == SBS_ENABLE_OFS)) |=> $stable(enable_r))
    else $error("enable register changed without a write");

    enable_read_a:
    assert property (ce && reg_rd && (reg_addr == SBS_ENABLE_OFS)
        |=> reg_rdata == $past(enable_r))
    else $error("enable register read returned wrong value");

    tx_cnt_step_a:
    assert property (ce && (tx_ovf || tx_unf) && !(reg_wr && (reg_addr == SBS_TX_CNT_OFS))
        && (tx_cnt_r != SBS_CNT_MAX) |=> tx_cnt_r == $past(tx_cnt_r) + 8'h01)
    else $error("transmit slip count did not step");

    rx_cnt_step_a:
    assert property (ce && (rx_ovf || rx_unf) && !(reg_wr && (reg_addr == SBS_RX_CNT_OFS))
        && (rx_cnt_r != SBS_CNT_MAX) |=> rx_cnt_r == $past(rx_cnt_r) + 8'h01)
    else $error("receive slip count did not step");

    tx_cnt_clear_a:
    assert property (ce && reg_wr && (reg_addr == SBS_TX_CNT_OFS) |=> tx_cnt_r == SBS_CNT_RST)
    else $error("transmit slip count not zeroed by a write");

    rx_cnt_clear_a:
    assert property (ce && reg_wr && (reg_addr == SBS_RX_CNT_OFS) |=> rx_cnt_r == SBS_CNT_RST)
    else $error("receive slip count not zeroed by a write");

    freeze_flags_a:
    assert property (!ce |=> $stable(flags))
    else $error("event flags moved while frozen");

    freeze_outputs_a:
    assert property (!ce |=> $stable(irq) && $stable(reg_rdata) && $stable(tx_frame_drop))
    else $error("outputs moved while frozen");

    rx_collide_a:
    assert property (ce && st_rd && rx_unf |=> flags[SBS_RX_UNF_BIT] && flags[SBS_RX_SLIP_BIT])
    else $error("receive event lost in the clearing cycle");

    irq_rise_a:
    assert property ($rose(irq) |-> $past(|(flags & enable_r)))
    else $error("interrupt rose without an enabled flag");

    unmapped_read_a:
    assert property (ce && reg_rd && (reg_addr > SBS_RX_CNT_OFS) |=> reg_rdata == '0)
    else $error("unmapped address read not zero");
endmodule
`default_nettype wire

// [sbs_sticky_flag.sv]
`timescale 1ns/1ps
`default_nettype none
module sbs_sticky_flag (
    // Clock, reset, freeze
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    // Event and clear
    input wire logic set,
    input wire logic clr,
    output logic flag
);
    logic flag_r;
    logic flag_nxt;

    // Set is checked last so an event in the clearing cycle survives
    always_comb begin
        flag_nxt = flag_r;
        if (clr) begin
            flag_nxt = 1'b0;
        end
        if (set) begin
            flag_nxt = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            flag_r <= 1'b0;
        end else if (ce) begin
            flag_r <= flag_nxt;
        end
    end

    assign flag = flag_r;
endmodule
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import sbs_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    // Clock enable drops once, late in the run, to show a frozen cycle records nothing
    logic ce = 1'b1;
    logic [SBS_ADDR_W-1:0] reg_addr = '0;
    logic [SBS_DATA_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [SBS_DATA_W-1:0] reg_rdata;
    logic tx_buf_full = 1'b0, tx_buf_wr = 1'b0, tx_buf_empty = 1'b0, tx_buf_rd = 1'b0;
    logic rx_buf_full = 1'b0, rx_buf_wr = 1'b0, rx_buf_empty = 1'b0, rx_buf_rd = 1'b0;
    logic loop_carrier_frame_sync = 1'b0;
    logic multiframe_lock = 1'b0;
    logic tx_frame_drop, tx_frame_repeat, rx_frame_drop, rx_frame_repeat, irq;
    int n_errors = 0;
    int n_compared = 0;
    int seed = 32'hb791;
    int r;
    logic [7:0] exp_fl = 8'h00;
    logic [7:0] en = 8'h00;
    logic [7:0] tx_slips = 8'h00;
    logic [7:0] rx_slips = 8'h00;

    sbs_slip_status i_sbs_slip_status (
        .clock(clock), .rst_n(rst_n), .ce(ce),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .tx_buf_full(tx_buf_full), .tx_buf_wr(tx_buf_wr), .tx_buf_empty(tx_buf_empty),
        .tx_buf_rd(tx_buf_rd), .tx_frame_drop(tx_frame_drop), .tx_frame_repeat(tx_frame_repeat),
        .rx_buf_full(rx_buf_full), .rx_buf_wr(rx_buf_wr), .rx_buf_empty(rx_buf_empty),
        .rx_buf_rd(rx_buf_rd), .rx_frame_drop(rx_frame_drop), .rx_frame_repeat(rx_frame_repeat),
        .loop_carrier_frame_sync(loop_carrier_frame_sync), .multiframe_lock(multiframe_lock),
        .irq(irq)
    );

    initial begin
        forever #12.5 clock = ~clock;
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input string what, input logic [7:0] exp);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        chk(what, exp, reg_rdata);
    endtask

    // Live lock bits sit beside the sticky flags
    function automatic logic [7:0] status_exp();
        return (exp_fl & SBS_EVENT_MASK)
            | {3'b000, loop_carrier_frame_sync, multiframe_lock, 3'b000};
    endfunction

    // Software can only tell a slip's direction from the flags beside it
    function automatic logic [7:0] dir_lost(input logic [7:0] s);
        return {6'h00, s[5] & ~(s[7] | s[6]), s[0] & ~(s[2] | s[1])};
    endfunction

    function automatic logic [7:0] ev_flags(input logic [7:0] x);
        logic o_t, u_t, o_r, u_r;
        o_t = x[7] & x[6];
        u_t = x[5] & x[4];
        o_r = x[3] & x[2];
        u_r = x[1] & x[0];
        return {o_t, u_t, o_t | u_t, 2'b00, o_r, u_r, o_r | u_r};
    endfunction

    // One cycle of buffer activity, optionally colliding with a status read
    task automatic ev(input logic [7:0] x, input logic rd_too);
        logic [7:0] f;
        logic [7:0] p;
        f = ev_flags(x);
        @(posedge clock);
        {tx_buf_full, tx_buf_wr, tx_buf_empty, tx_buf_rd} <= x[7:4];
        {rx_buf_full, rx_buf_wr, rx_buf_empty, rx_buf_rd} <= x[3:0];
        if (rd_too) begin
            reg_rd <= 1'b1;
            reg_addr <= SBS_STATUS_OFS;
        end
        @(posedge clock);
        {tx_buf_full, tx_buf_wr, tx_buf_empty, tx_buf_rd} <= 4'h0;
        {rx_buf_full, rx_buf_wr, rx_buf_empty, rx_buf_rd} <= 4'h0;
        reg_rd <= 1'b0;
        #1;
        p = {4'h0, tx_frame_drop, tx_frame_repeat, rx_frame_drop, rx_frame_repeat};
        chk("slip pulses", {4'h0, f[7], f[6], f[2], f[1]}, p);
        if (rd_too) begin
            chk("status at colliding read", status_exp(), reg_rdata);
        end
        exp_fl = rd_too ? f : (exp_fl | f);
        tx_slips = tx_slips + {7'h00, f[5]};
        rx_slips = rx_slips + {7'h00, f[0]};
    endtask

    task automatic summarize();
        $display("counts: %0d compared, %0d mismatches", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        #(25 * 100000);
        n_errors++;
        summarize();
    end

    initial begin
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        rd(SBS_STATUS_OFS, "status after reset", SBS_STATUS_RST);
        rd(SBS_ENABLE_OFS, "enable after reset", SBS_ENABLE_RST);
        rd(4'hF, "unmapped read", 8'h00);
        $display("test reset done");
        // Slip in the very cycle of the clearing read must survive
        ev(8'hC0, 1'b0);
        ev(8'h33, 1'b1);
        rd(SBS_STATUS_OFS, "status after collision", status_exp());
        exp_fl = 8'h00;
        rd(SBS_STATUS_OFS, "status cleared", status_exp());
        $display("test collision done");
        for (int i = 0; i < 80; i++) begin
            r = $random(seed);
            @(posedge clock);
            loop_carrier_frame_sync <= r[8];
            multiframe_lock <= r[9];
            if (r[10]) begin
                wr(SBS_ENABLE_OFS, r[23:16]);
                en = r[23:16] & SBS_EVENT_MASK;
                rd(SBS_ENABLE_OFS, "enable readback", en);
            end
            ev(r[7:0], 1'b0);
            @(posedge clock);
            #1;
            chk("irq", {7'h00, |(exp_fl & en)}, {7'h00, irq});
            if (r[12]) begin
                rd(SBS_STATUS_OFS, "status", status_exp());
                chk("slip direction", 8'h00, dir_lost(reg_rdata));
                exp_fl = 8'h00;
            end
        end
        $display("test random done");
        // Masked events are still recorded; write-one clears one flag only
        wr(SBS_ENABLE_OFS, 8'h00);
        en = 8'h00;
        rd(SBS_STATUS_OFS, "status flush", status_exp());
        exp_fl = 8'h00;
        ev(8'h03, 1'b0);
        @(posedge clock);
        #1;
        chk("irq masked", 8'h00, {7'h00, irq});
        wr(SBS_STATUS_OFS, 8'h1A);
        exp_fl = exp_fl & 8'hFD;
        // An overflow offered in a frozen cycle must leave no trace
        @(posedge clock);
        ce <= 1'b0;
        {tx_buf_full, tx_buf_wr} <= 2'b11;
        @(posedge clock);
        ce <= 1'b1;
        {tx_buf_full, tx_buf_wr} <= 2'b00;
        #1;
        chk("frozen drop", 8'h00, {7'h00, tx_frame_drop});
        rd(SBS_STATUS_OFS, "status after clear", status_exp());
        $display("test mask done");
        rd(SBS_TX_CNT_OFS, "tx slip count", tx_slips);
        rd(SBS_RX_CNT_OFS, "rx slip count", rx_slips);
        wr(SBS_TX_CNT_OFS, 8'h5A);
        wr(SBS_RX_CNT_OFS, 8'hA5);
        rd(SBS_TX_CNT_OFS, "tx count cleared", SBS_CNT_RST);
        rd(SBS_RX_CNT_OFS, "rx count cleared", SBS_CNT_RST);
        $display("test count done");
        summarize();
    end
endmodule
`default_nettype wire
